// ---- ecltc_bank.sv ----
/*
  Read latency, interrupt control and check-engine test registers of a serial memory.
  Link side runs on link_clk_i, driven by the instruction decoder; the core side on clock_i.
  Assumes the decoder presents one register request at a time and holds write-enable state.
*/
`default_nettype none

module ecltc_bank #(
  parameter bit READY_IRQ_EN = 1'b0
) (
  input  wire logic                            clock_i,
  input  wire logic                            rst_i,
  input  wire logic                            link_clk_i,
  input  wire logic                            reg_wr_i,
  input  wire logic                            read_start_i,
  input  wire logic                            read_is_reg_i,
  input  wire logic [ecltc_pkg::ADDR_W-1:0]    reg_addr_i,
  input  wire logic [ecltc_pkg::WORD_W-1:0]    reg_wdata_i,
  input  wire logic                            write_enable_latch_i,
  input  wire logic                            uncorrectable_event_i,
  input  wire logic                            device_ready_i,
  output logic                                 data_phase_o,
  output logic [ecltc_pkg::WORD_W-1:0]         reg_rdata_o,
  output logic [ecltc_pkg::LAT_W-1:0]          latency_cycle_select_o,
  output logic                                 int_n_o,
  output logic [ecltc_pkg::DIE_W-1:0]          die_or_detect_select_o,
  output logic                                 check_engine_test_enable_o
);
  import ecltc_pkg::*;

  // ==========================================================================
  // Link domain state
  logic              link_rst;
  logic              req_tgl;
  logic              ack_sync;
  ecltc_req_t        hold_kind;
  logic [ADDR_W-1:0] hold_addr;
  logic [WORD_W-1:0] hold_data;
  logic              chan_busy;
  logic              lat_run;
  logic              lat_is_reg;
  logic [LAT_W-1:0]  lat_cnt;
  logic              wr_take;
  logic              rd_take;
  logic [LAT_W:0]    lat_age;

  // ==========================================================================
  // Core domain state
  logic              req_sync;
  logic              req_seen;
  logic              ack_tgl;
  logic              req_new;
  logic              core_wr;
  logic [WORD_W-1:0] rdata_hold;
  logic              uncorrectable_flag;
  logic              detect_en;
  logic [WORD_W-1:0] test_in;
  logic [WORD_W-1:0] test_mask;
  logic [WORD_W-1:0] result_word;
  logic [WORD_W-1:0] uncorrectable_tally;
  logic              irq_pending;
  logic              irq_clear_strobe;
  logic              tally_clear_strobe;
  logic              eng_start;
  logic              eng_done;
  logic              eng_unc;
  logic [WORD_W-1:0] eng_result;
  logic              ready_q;
  logic              ready_rise;
  logic              err_event;
  logic              irq_event;

  // ==========================================================================
  // Crossings: reset into link domain, request toggle in, ack toggle out
  ecltc_sync #(.RESET_VAL(1'b1)) u_rst_sync (
    .clk_i (link_clk_i),
    .rst_i (1'b0),
    .d_i   (rst_i),
    .q_o   (link_rst)
  );

  ecltc_sync #(.RESET_VAL(1'b0)) u_ack_sync (
    .clk_i (link_clk_i),
    .rst_i (link_rst),
    .d_i   (ack_tgl),
    .q_o   (ack_sync)
  );

  ecltc_sync #(.RESET_VAL(1'b0)) u_req_sync (
    .clk_i (clock_i),
    .rst_i (rst_i),
    .d_i   (req_tgl),
    .q_o   (req_sync)
  );

  // ==========================================================================
  // Link side: accept one request at a time; held words stay put until acked
  assign chan_busy = (req_tgl != ack_sync);
  assign wr_take   = reg_wr_i && write_enable_latch_i && !chan_busy;
  assign rd_take   = read_start_i && read_is_reg_i && !chan_busy && !lat_run;

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      req_tgl   <= 1'b0;
      hold_kind <= ECLTC_REQ_WRITE;
      hold_addr <= '0;
      hold_data <= WORD_RESET;
    end else if (wr_take || rd_take) begin
      req_tgl   <= !req_tgl;
      hold_kind <= wr_take ? ECLTC_REQ_WRITE : ECLTC_REQ_READ;
      hold_addr <= reg_addr_i;
      hold_data <= reg_wdata_i;
    end
  end

  // Latency lives here because the link side times the data phase
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      latency_cycle_select_o <= LAT_RESET;
    end else if (wr_take && reg_addr_i == ADDR_LATENCY) begin
      latency_cycle_select_o <= reg_wdata_i[LAT_W-1:0];
    end
  end

  // ==========================================================================
  // Latency count: data phase after the programmed cycles, and after the
  // core answered for register reads, so a short latency never shows stale data
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      lat_run      <= 1'b0;
      lat_is_reg   <= 1'b0;
      lat_cnt      <= '0;
      data_phase_o <= 1'b0;
    end else begin
      data_phase_o <= 1'b0;
      if (read_start_i && !lat_run && (!read_is_reg_i || !chan_busy)) begin
        lat_run    <= 1'b1;
        lat_is_reg <= read_is_reg_i;
        lat_cnt    <= latency_cycle_select_o;
      end else if (lat_run && lat_cnt != '0) begin
        lat_cnt <= lat_cnt - 1'b1;
      end else if (lat_run && !(lat_is_reg && chan_busy)) begin
        lat_run      <= 1'b0;
        data_phase_o <= 1'b1;
      end
    end
  end

  // Register read data is taken once the ack has crossed; rdata_hold is steady
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      reg_rdata_o <= WORD_RESET;
    end else if (lat_run && lat_cnt == '0 && lat_is_reg && !chan_busy) begin
      reg_rdata_o <= (hold_addr == ADDR_LATENCY) ?
                     {{(WORD_W-LAT_W){1'b0}}, latency_cycle_select_o} : rdata_hold;
    end
  end

  // ==========================================================================
  // Core side: a new toggle is one request; answer by flipping ack back
  assign req_new            = (req_sync != req_seen);
  assign core_wr            = req_new && (hold_kind == ECLTC_REQ_WRITE);
  assign irq_clear_strobe   = core_wr && hold_addr == ADDR_INTCTL && hold_data[IRQ_CLR_BIT];
  assign tally_clear_strobe = core_wr && hold_addr == ADDR_INTCTL && hold_data[TALLY_CLR_BIT];

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      req_seen <= 1'b0;
      ack_tgl  <= 1'b0;
    end else begin
      req_seen <= req_sync;
      ack_tgl  <= req_sync;
    end
  end

  // Read mux; unmapped indices and write-only bits read as zero
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_hold <= WORD_RESET;
    end else if (req_new && hold_kind == ECLTC_REQ_READ) begin
      unique case (hold_addr)
        ADDR_INTCTL:  rdata_hold <= {24'h000000, uncorrectable_flag, 3'h0,
                                     die_or_detect_select_o,
                                     check_engine_test_enable_o, detect_en};
        ADDR_TEST_IN: rdata_hold <= test_in;
        ADDR_FLIP:    rdata_hold <= test_mask;
        ADDR_RESULT:  rdata_hold <= result_word;
        ADDR_TALLY:   rdata_hold <= uncorrectable_tally;
        default:      rdata_hold <= WORD_RESET;
      endcase
    end
  end

  // ==========================================================================
  // Control bits of interrupt_and_ecc_test_control
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      die_or_detect_select_o     <= DIE_RESET;
      check_engine_test_enable_o <= 1'b0;
      detect_en                  <= 1'b0;
    end else if (core_wr && hold_addr == ADDR_INTCTL) begin
      die_or_detect_select_o     <= hold_data[DIE_LSB+DIE_W-1:DIE_LSB];
      check_engine_test_enable_o <= hold_data[TEST_EN_BIT];
      detect_en                  <= hold_data[DETECT_EN_BIT];
    end
  end

  // Test words; a write while in test mode launches the engine next cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      test_in   <= WORD_RESET;
      test_mask <= WORD_RESET;
      eng_start <= 1'b0;
    end else begin
      eng_start <= core_wr && check_engine_test_enable_o &&
                   (hold_addr == ADDR_TEST_IN || hold_addr == ADDR_FLIP);
      if (core_wr && hold_addr == ADDR_TEST_IN) begin
        test_in <= hold_data;
      end
      if (core_wr && hold_addr == ADDR_FLIP) begin
        test_mask <= hold_data;
      end
    end
  end

  ecltc_check_engine #(.W(WORD_W)) u_engine (
    .clk_i           (clock_i),
    .rst_i           (rst_i),
    .start_i         (eng_start),
    .data_i          (test_in),
    .mask_i          (test_mask),
    .done_o          (eng_done),
    .uncorrectable_o (eng_unc),
    .result_o        (eng_result)
  );

  // ==========================================================================
  // Result word and tally; an increment in the clear cycle still counts
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      result_word         <= WORD_RESET;
      uncorrectable_tally <= WORD_RESET;
    end else begin
      if (eng_done) begin
        result_word <= eng_result;
      end
      if (tally_clear_strobe) begin
        uncorrectable_tally <= {{(WORD_W-1){1'b0}}, eng_unc};
      end else if (eng_unc) begin
        uncorrectable_tally <= uncorrectable_tally + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Events: test-mode or live uncorrectable errors, and busy-to-ready
  assign err_event  = eng_unc || uncorrectable_event_i;
  assign ready_rise = READY_IRQ_EN && device_ready_i && !ready_q;
  assign irq_event  = (err_event && detect_en) || ready_rise;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= device_ready_i;
    end
  end

  // Set wins over clear so an event in the clearing cycle is never lost
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      uncorrectable_flag <= 1'b0;
      irq_pending        <= 1'b0;
      int_n_o            <= 1'b1;
    end else begin
      if (err_event) begin
        uncorrectable_flag <= 1'b1;
      end else if (irq_clear_strobe) begin
        uncorrectable_flag <= 1'b0;
      end
      if (irq_event) begin
        irq_pending <= 1'b1;
      end else if (irq_clear_strobe) begin
        irq_pending <= 1'b0;
      end
      int_n_o <= !irq_pending;
    end
  end

  // ==========================================================================
  // Checks
  always_ff @(posedge link_clk_i) begin
    if (link_rst || !lat_run) begin
      lat_age <= '0;
    end else if (lat_age != '1) begin
      lat_age <= lat_age + 1'b1;
    end
  end

  lat_timing_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    data_phase_o && !lat_is_reg |->
      lat_age == {1'b0, $past(latency_cycle_select_o, 2)} + 5'h01)
    else $error("array data phase not at programmed latency");

  lat_store_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    wr_take && reg_addr_i == ADDR_LATENCY |=>
      latency_cycle_select_o == $past(reg_wdata_i[LAT_W-1:0]))
    else $error("latency field not stored");

  irq_fall_a: assert property (@(posedge clock_i) disable iff (rst_i)
    eng_unc && detect_en |-> ##2 !int_n_o)
    else $error("interrupt output did not fall on enabled error");

  flag_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
    err_event |=> uncorrectable_flag)
    else $error("uncorrectable flag not set");

  irq_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
    irq_clear_strobe && !irq_event ##1 !irq_event |-> ##1 int_n_o && !irq_pending)
    else $error("interrupt not released by clear strobe");

  tally_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
    tally_clear_strobe && !eng_unc |=> uncorrectable_tally == WORD_RESET)
    else $error("tally not cleared");

  tally_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
    eng_unc && !tally_clear_strobe |=>
      uncorrectable_tally == $past(uncorrectable_tally) + 32'h0000_0001)
    else $error("tally did not step by one");

  test_gate_a: assert property (@(posedge clock_i) disable iff (rst_i)
    eng_start |-> $past(check_engine_test_enable_o))
    else $error("engine ran outside test mode");

  mask_flip_a: assert property (@(posedge clock_i) disable iff (rst_i)
    eng_unc |=> result_word == (test_in ^ test_mask))
    else $error("result is not the masked word");

  die_store_a: assert property (@(posedge clock_i) disable iff (rst_i)
    core_wr && hold_addr == ADDR_INTCTL |=>
      die_or_detect_select_o == $past(hold_data[DIE_LSB+DIE_W-1:DIE_LSB]))
    else $error("die selection not stored");

  silent_mask_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !detect_en && !ready_rise && !irq_pending |=> !irq_pending)
    else $error("interrupt raised while detection disabled");

endmodule : ecltc_bank

`default_nettype wire

// ---- ecltc_bank_tb_top.sv ----
/*
  Self-checking bench of the latency, interrupt and check-engine register bank.
  Assumes ecltc_pkg, ecltc_bank and ecltc_host_model are compiled before it.
*/
`default_nettype none
module ecltc_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ecltc_pkg::*;

  // ==========================================================================
  // Signals
  logic clock_i, rst_i, link_clk_i, reg_wr_i, read_start_i, read_is_reg_i;
  logic write_enable_latch_i, uncorrectable_event_i, device_ready_i;
  logic data_phase_o, int_n_o, check_engine_test_enable_o;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [WORD_W-1:0] reg_wdata_i, reg_rdata_o, din, exp_q[$];
  logic [LAT_W-1:0]  latency_cycle_select_o;
  logic [DIE_W-1:0]  die_or_detect_select_o;
  int     errors = 0, n_tests = 0, n, cur_lat = 8;
  int     lats[4] = '{0, 1, 12, 15};
  integer seed = 32'h79A3;

  // Core 40 ns; link 64 ns with an odd offset so edges drift apart
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #32 link_clk_i = ~link_clk_i;
  end

  ecltc_bank #(.READY_IRQ_EN(1'b0)) DUT (
    .clock_i, .rst_i, .link_clk_i, .reg_wr_i, .read_start_i, .read_is_reg_i,
    .reg_addr_i, .reg_wdata_i, .write_enable_latch_i, .uncorrectable_event_i,
    .device_ready_i, .data_phase_o, .reg_rdata_o, .latency_cycle_select_o,
    .int_n_o, .die_or_detect_select_o, .check_engine_test_enable_o);
  ecltc_host_model host (
    .link_clk_i, .data_phase_i(data_phase_o), .reg_wr_o(reg_wr_i),
    .read_start_o(read_start_i), .read_is_reg_o(read_is_reg_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .write_enable_latch_o(write_enable_latch_i));

  // ==========================================================================
  // Checking
  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    // A queued read word that never met its data phase is a lost answer
    if (exp_q.size() != 0) errors++;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // Register read: expected word queued, count checked once latency covers the crossing
  task automatic rreg(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] e);
    exp_q.push_back(e);
    host.rd(a, 1'b1, n);
    if (n >= 60) begin
      errors++;
      summarize();
    end
    if (cur_lat >= 8) chk(n, cur_lat + 1);
  endtask : rreg

  task automatic wait_int(input logic v);
    int k;
    k = 0;
    while (k < 80 && int_n_o !== v) begin
      @(posedge clock_i);
      #1;
      k++;
    end
    chk({31'h0, int_n_o}, {31'h0, v});
    if (k == 80) summarize();
  endtask : wait_int

  // Watcher: each register data phase takes the oldest queued word
  always @(posedge link_clk_i) begin
    #1;
    if (data_phase_o === 1'b1 && read_is_reg_i === 1'b1) begin
      if (exp_q.size() == 0) chk(reg_rdata_o, ~reg_rdata_o);
      else chk(reg_rdata_o, exp_q.pop_front());
    end
  end

  // ==========================================================================
  // Scenarios
  initial begin
    rst_i = 1'b1;
    uncorrectable_event_i = 1'b0;
    device_ready_i = 1'b0;
    repeat (6) @(posedge clock_i);
    #2;
    rst_i = 1'b0;
    chk(WORD_W'(latency_cycle_select_o), 32'h8);
    chk({29'h0, int_n_o, die_or_detect_select_o}, 32'h4);
    chk(WORD_W'(check_engine_test_enable_o), 32'h0);
    host.idle(4);
    rreg(ADDR_LATENCY, 32'h8);
    rreg(ADDR_INTCTL, 32'h0);
    for (int a = 2; a < 7; a++) rreg(ADDR_W'(a), WORD_RESET);
    host.wr(ADDR_LATENCY, 32'hF, 1'b0);
    rreg(ADDR_LATENCY, 32'h8);
    $display("Test reset and refused write done");
    foreach (lats[i]) begin
      host.wr(ADDR_LATENCY, WORD_W'(lats[i]), 1'b1);
      chk(WORD_W'(latency_cycle_select_o), WORD_W'(lats[i]));
      host.rd(ADDR_LATENCY, 1'b0, n);
      chk(n, lats[i] + 1);
      if (n >= 60) summarize();
    end
    host.wr(ADDR_LATENCY, 32'hFFFF_FFF9, 1'b1);
    cur_lat = 9;
    rreg(ADDR_LATENCY, 32'h9);
    $display("Test latency done");
    for (int d = 0; d < 4; d++) begin
      host.wr(ADDR_INTCTL, WORD_W'(d << 2), 1'b1);
      chk(WORD_W'(die_or_detect_select_o), WORD_W'(d));
      rreg(ADDR_INTCTL, WORD_W'(d << 2));
    end
    $display("Test die select done");
    host.wr(ADDR_INTCTL, 32'hF, 1'b1);
    chk(WORD_W'(check_engine_test_enable_o), 32'h1);
    din = $random(seed);
    host.wr(ADDR_TEST_IN, din, 1'b1);
    rreg(ADDR_TEST_IN, din);
    host.wr(ADDR_FLIP, 32'h1, 1'b1);
    rreg(ADDR_RESULT, din);
    rreg(ADDR_TALLY, 32'h0);
    wait_int(1'b1);
    host.wr(ADDR_FLIP, 32'h3, 1'b1);
    rreg(ADDR_FLIP, 32'h3);
    rreg(ADDR_RESULT, din ^ 32'h3);
    rreg(ADDR_TALLY, 32'h1);
    rreg(ADDR_INTCTL, 32'h8F);
    wait_int(1'b0);
    $display("Test check engine done");
    host.wr(ADDR_INTCTL, 32'h4F, 1'b1);
    wait_int(1'b1);
    rreg(ADDR_INTCTL, 32'hF);
    rreg(ADDR_TALLY, 32'h1);
    host.wr(ADDR_INTCTL, 32'h2F, 1'b1);
    rreg(ADDR_TALLY, 32'h0);
    host.wr(ADDR_INTCTL, 32'hE, 1'b1);
    host.wr(ADDR_FLIP, 32'h5, 1'b1);
    rreg(ADDR_TALLY, 32'h1);
    chk(WORD_W'(int_n_o), 32'h1);
    rreg(ADDR_INTCTL, 32'h8E);
    $display("Test clear and detect select done");
    host.wr(ADDR_INTCTL, 32'h4D, 1'b1);
    wait_int(1'b1);
    @(posedge clock_i);
    #2;
    uncorrectable_event_i = 1'b1;
    device_ready_i = 1'b1;
    @(posedge clock_i);
    #2;
    uncorrectable_event_i = 1'b0;
    wait_int(1'b0);
    rreg(ADDR_INTCTL, 32'h8D);
    $display("Test live event done");
    summarize();
  end
endmodule : ecltc_bank_tb_top
`default_nettype wire

// ---- ecltc_check_engine.sv ----
/*
  Check engine used in test mode: flips the buffered word with a mask and judges it.
  Assumes data_i and mask_i stay stable while start_i is high.
*/
`default_nettype none

module ecltc_check_engine #(
  parameter int W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] data_i,
  input  wire logic [W-1:0] mask_i,
  output logic              done_o,
  output logic              uncorrectable_o,
  output logic [W-1:0]      result_o
);

  logic [$clog2(W+1)-1:0] flips;

  initial begin
    if (W < 2) $error("ecltc_check_engine: W must be at least 2");
  end

  // ==========================================================================
  // Count injected flips; one flip is corrected, two or more are not
  always_comb begin
    flips = '0;
    for (int i = 0; i < W; i++) begin
      flips = flips + {{($clog2(W+1)-1){1'b0}}, mask_i[i]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o          <= 1'b0;
      uncorrectable_o <= 1'b0;
      result_o        <= '0;
    end else begin
      done_o          <= start_i;
      uncorrectable_o <= start_i && (flips > 1);
      if (start_i) begin
        // A single flip is repaired, so the clean word comes back
        result_o <= (flips > 1) ? (data_i ^ mask_i) : data_i;
      end
    end
  end

endmodule : ecltc_check_engine

`default_nettype wire

// ---- ecltc_host_model.sv ----
/*
  Host model: drives the link side of the register bank, one request at a time.
  Assumes link_clk_i runs and the bank's link side is out of reset before use.
*/
`default_nettype none
module ecltc_host_model (
  input  wire logic                         link_clk_i,
  input  wire logic                         data_phase_i,
  output logic                              reg_wr_o,
  output logic                              read_start_o,
  output logic                              read_is_reg_o,
  output logic [ecltc_pkg::ADDR_W-1:0]      reg_addr_o,
  output logic [ecltc_pkg::WORD_W-1:0]      reg_wdata_o,
  output logic                              write_enable_latch_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import ecltc_pkg::*;

  // ==========================================================================
  // Idle levels at time zero
  initial begin
    reg_wr_o = 1'b0;
    read_start_o = 1'b0;
    read_is_reg_o = 1'b0;
    reg_addr_o = '0;
    reg_wdata_o = '0;
    write_enable_latch_o = 1'b0;
  end

  task automatic idle(input int cnt);
    repeat (cnt) @(posedge link_clk_i);
  endtask : idle

  // Write; lines are inverted afterwards so stale values never look valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d, input logic wel);
    @(posedge link_clk_i);
    #2;
    write_enable_latch_o = wel;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge link_clk_i);
    #2;
    reg_wr_o = 1'b0;
    write_enable_latch_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
    idle(10);
  endtask : wr

  // Read; cnt is the link edge of the data phase, the start edge being 0
  task automatic rd(input logic [ADDR_W-1:0] a, input logic is_reg, output int cnt);
    @(posedge link_clk_i);
    #2;
    reg_addr_o = a;
    read_is_reg_o = is_reg;
    read_start_o = 1'b1;
    @(posedge link_clk_i);
    #2;
    read_start_o = 1'b0;
    cnt = 0;
    while (cnt < 60 && data_phase_i !== 1'b1) begin
      @(posedge link_clk_i);
      #1;
      cnt++;
    end
    // Qualifier held one edge more so the bench's watcher still sees it
    @(posedge link_clk_i);
    #2;
    read_is_reg_o = 1'b0;
    reg_addr_o = ~a;
    idle(10);
  endtask : rd
endmodule : ecltc_host_model
`default_nettype wire

// ---- ecltc_pkg.sv ----
/*
  Constants shared by the latency, interrupt and check-engine test register bank.
  Assumes register indices are carried by the link's instruction decoder as 8-bit values.
*/
`default_nettype none

package ecltc_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W = 8;
  localparam int WORD_W = 32;
  localparam int LAT_W  = 4;
  localparam int DIE_W  = 2;

  // ==========================================================================
  // Register indices
  localparam logic [ADDR_W-1:0] ADDR_LATENCY = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_INTCTL  = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_TEST_IN = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_FLIP    = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_RESULT  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_TALLY   = 8'h05;

  // ==========================================================================
  // Field positions of interrupt_and_ecc_test_control
  localparam int FLAG_BIT      = 7;
  localparam int IRQ_CLR_BIT   = 6;
  localparam int TALLY_CLR_BIT = 5;
  localparam int DIE_LSB       = 2;
  localparam int TEST_EN_BIT   = 1;
  localparam int DETECT_EN_BIT = 0;

  // ==========================================================================
  // Reset values
  localparam logic [LAT_W-1:0]  LAT_RESET  = 4'h8;
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [DIE_W-1:0]  DIE_RESET  = 2'h0;

  // Request kinds carried across the clock crossing
  typedef enum logic {
    ECLTC_REQ_WRITE,
    ECLTC_REQ_READ
  } ecltc_req_t;

endpackage : ecltc_pkg

`default_nettype wire

// ---- ecltc_sync.sv ----
/*
  Two-flop level synchroniser.
  Assumes d_i is a level that is stable for at least two destination clock edges.
*/
`default_nettype none

module ecltc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta;

  // ==========================================================================
  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= RESET_VAL;
      q_o  <= RESET_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule : ecltc_sync

`default_nettype wire
